// >>> shared/fmw_pkg.sv
// Package of constants and types shared by both ends of the FM write channel.
package fmw_pkg;

    localparam int CYL_W         = 9;
    localparam int HEAD_COUNT    = 4;
    // Cylinder at which the reduced write current starts.
    localparam logic [8:0] CYL_SWITCH_100TPI = 9'h080;
    localparam logic [8:0] CYL_SWITCH_200TPI = 9'h100;
    // Host bit-cell timing: cycles per half cell.
    localparam logic [7:0] HALF_CELL_CYCLES  = 8'h04;
    localparam logic [7:0] HALF_CELL_RST     = 8'h00;

    typedef enum {
        HST_IDLE,
        HST_CLOCK,
        HST_DATA
    } fmw_host_state_t;

endpackage : fmw_pkg

// >>> shared/fmw_link_if.sv
// Interface carrying the select, gate and write pulse lines between host and drive.
`timescale 1ns/1ps
`default_nettype none
interface fmw_link_if;
    logic       platterChoiceLine;
    logic       surfaceChoiceLine;
    logic [3:0] headSelectOneHot;
    logic       writeGateN;
    logic       writePulseLine;
    logic       emergency;

    modport host (
        output platterChoiceLine,
        output surfaceChoiceLine,
        output writeGateN,
        output writePulseLine,
        input  emergency,
        input  headSelectOneHot
    );
    modport drive (
        input  platterChoiceLine,
        input  surfaceChoiceLine,
        input  writeGateN,
        input  writePulseLine,
        output emergency,
        output headSelectOneHot
    );
endinterface : fmw_link_if
`default_nettype wire

// >>> verilog/fmw_toggle_driver.sv
// Toggle flip-flop that steers write current between the two coil halves.
`timescale 1ns/1ps
`default_nettype none
module fmw_toggle_driver (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic togglePulse,
    input  wire logic driveEnable,
    output logic      coilHalfA,
    output logic      coilHalfB
);
    typedef struct packed {
        logic phase;
        logic a;
        logic b;
    } fmw_tog_t;

    fmw_tog_t s_q;
    fmw_tog_t s_d;

    always_comb begin
        s_d = s_q;
        if (togglePulse) begin
            s_d.phase = ~s_q.phase;
        end
        s_d.a = driveEnable & s_d.phase;
        s_d.b = driveEnable & ~s_d.phase;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign coilHalfA = s_q.a;
    assign coilHalfB = s_q.b;
endmodule : fmw_toggle_driver
`default_nettype wire

// >>> verilog/fmw_drive_end.sv
// Drive end: head decode, write gating, drivers, current control and emergency monitor.
`timescale 1ns/1ps
`default_nettype none
module fmw_drive_end (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    fmw_link_if.drive                      link,
    input  wire logic                      unitReady,
    input  wire logic                      onLegalTrack,
    input  wire logic                      writeProtect,
    input  wire logic                      powerGoodClear,
    input  wire logic                      tpi200,
    input  wire logic [fmw_pkg::CYL_W-1:0] cylinder,
    input  wire logic                      writeCurrentSensed,
    input  wire logic                      eraseCurrentSensed,
    output logic                           writeModeEnableN,
    output logic                           eraseCurrentEnableN,
    output logic                           writeTogglePulse,
    output logic                           highCurrentLevel,
    output logic                           currentMonitorN,
    output logic                           coilHalfA,
    output logic                           coilHalfB
);
    typedef struct packed {
        logic [3:0] heads;
        logic [3:0] cause;
        logic       wmN;
        logic       ecN;
        logic       toggle;
        logic       hiCur;
        logic       monN;
        logic       emerg;
        logic       pulsePrev;
        logic       pathOpen;
    } fmw_drv_t;

    fmw_drv_t   s_q;
    fmw_drv_t   s_d;
    logic [3:0] headHit;
    logic [1:0] headIdx;
    logic       ready;
    logic       multiHead;
    logic       gateLow;
    logic       pulseRise;
    logic       anySense;
    logic       readState;
    logic       below100;
    logic       below200;
    logic       writeEn;

    // The platter line is the high bit of the head index, the surface line the low bit.
    assign headIdx = {link.platterChoiceLine, link.surfaceChoiceLine};

    // Each head compares the index against its own number.
    for (genvar h = 0; h < fmw_pkg::HEAD_COUNT; h++) begin : g_head
        assign headHit[h] = (headIdx == 2'(h));
    end

    assign multiHead = (s_q.heads & (s_q.heads - 4'h1)) != 4'h0;
    assign gateLow   = ~link.writeGateN;
    assign pulseRise = link.writePulseLine & ~s_q.pulsePrev;
    assign anySense  = writeCurrentSensed | eraseCurrentSensed;
    assign readState = s_q.wmN & s_q.ecN;
    assign below100  = cylinder < fmw_pkg::CYL_SWITCH_100TPI;
    assign below200  = cylinder < fmw_pkg::CYL_SWITCH_200TPI;
    assign ready     = unitReady
                     & onLegalTrack
                     & ~writeProtect
                     & powerGoodClear
                     & ~multiHead;

    always_comb begin
        s_d = s_q;
        s_d.heads = headHit;

        // Write mode needs the gate low and every readiness condition met.
        if (gateLow && ready) begin
            s_d.wmN = 1'b0;
        end else begin
            s_d.wmN = 1'b1;
        end

        // Erase follows write mode and is never enabled without power good.
        if (!s_d.wmN && powerGoodClear) begin
            s_d.ecN = 1'b0;
        end else begin
            s_d.ecN = 1'b1;
        end

        if (powerGoodClear) begin
            s_d.pathOpen = 1'b0;
        end else begin
            s_d.pathOpen = 1'b1;
        end

        // A rising write line raises the toggle pulse in the same cycle that write mode starts; the coil flips a cycle later.
        if (!s_d.wmN && pulseRise) begin
            s_d.toggle = 1'b1;
        end else begin
            s_d.toggle = 1'b0;
        end
        s_d.pulsePrev = link.writePulseLine;

        if (tpi200) begin
            if (below200) begin
                s_d.hiCur = 1'b1;
            end else begin
                s_d.hiCur = 1'b0;
            end
        end else begin
            if (below100) begin
                s_d.hiCur = 1'b1;
            end else begin
                s_d.hiCur = 1'b0;
            end
        end

        if (anySense) begin
            s_d.monN = 1'b0;
        end else begin
            s_d.monN = 1'b1;
        end

        // Each cause is computed apart, and the emergency is the OR of all four causes.
        if (multiHead) begin
            s_d.cause[0] = 1'b1;
        end else begin
            s_d.cause[0] = 1'b0;
        end

        if (writeCurrentSensed && s_q.wmN) begin
            s_d.cause[1] = 1'b1;
        end else begin
            s_d.cause[1] = 1'b0;
        end

        if (eraseCurrentSensed && s_q.ecN) begin
            s_d.cause[2] = 1'b1;
        end else begin
            s_d.cause[2] = 1'b0;
        end

        if (readState && !s_q.monN) begin
            s_d.cause[3] = 1'b1;
        end else begin
            s_d.cause[3] = 1'b0;
        end

        s_d.emerg = |s_d.cause;
    end

    // Reset leaves the drive in the reading state with high current selected.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q       <= '0;
            s_q.wmN   <= 1'b1;
            s_q.ecN   <= 1'b1;
            s_q.monN  <= 1'b1;
            s_q.hiCur <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign writeEn = ~s_q.wmN & ~s_q.pathOpen;

    // The toggle stage drives both coil halves from its own flip-flops.
    fmw_toggle_driver u_toggle (
        .clk         (clk),
        .nrst        (nrst),
        .togglePulse (s_q.toggle),
        .driveEnable (writeEn),
        .coilHalfA   (coilHalfA),
        .coilHalfB   (coilHalfB)
    );

    assign link.emergency        = s_q.emerg;
    assign link.headSelectOneHot = s_q.heads;
    assign writeModeEnableN      = s_q.wmN;
    assign eraseCurrentEnableN   = s_q.ecN;
    assign writeTogglePulse      = s_q.toggle;
    assign highCurrentLevel      = s_q.hiCur;
    assign currentMonitorN       = s_q.monN;
endmodule : fmw_drive_end
`default_nettype wire

// >>> verilog/fmw_host_end.sv
// Host end: selects a head, gates writing and FM-encodes a serial bit stream.
`timescale 1ns/1ps
`default_nettype none
module fmw_host_end (
    input  wire logic   clk,
    input  wire logic   nrst,
    fmw_link_if.host    link,
    input  wire logic [1:0] headIndex,
    input  wire logic   driveReady,
    input  wire logic   bitValid,
    input  wire logic   bitData,
    output logic        bitReady,
    output logic        busy
);
    typedef struct packed {
        fmw_pkg::fmw_host_state_t st;
        logic [7:0] cnt;
        logic       dataBit;
        logic       pulse;
        logic       gateN;
        logic [1:0] head;
        logic       rdy;
    } fmw_host_t;

    fmw_host_t s_q;
    fmw_host_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.pulse = 1'b0;
        s_d.rdy = 1'b0;
        case (s_q.st)
            fmw_pkg::HST_IDLE: begin
                s_d.head = headIndex;
                s_d.gateN = 1'b1;
                if (bitValid && driveReady && !link.emergency) begin
                    s_d.gateN = 1'b0;
                    s_d.dataBit = bitData;
                    s_d.rdy = 1'b1;
                    s_d.pulse = 1'b1;
                    s_d.cnt = fmw_pkg::HALF_CELL_RST;
                    s_d.st = fmw_pkg::HST_CLOCK;
                end
            end
            fmw_pkg::HST_CLOCK: begin
                s_d.cnt = s_q.cnt + 8'h01;
                if (s_q.cnt == fmw_pkg::HALF_CELL_CYCLES - 8'h01) begin
                    s_d.cnt = fmw_pkg::HALF_CELL_RST;
                    s_d.pulse = s_q.dataBit;
                    s_d.st = fmw_pkg::HST_DATA;
                end
            end
            fmw_pkg::HST_DATA: begin
                s_d.cnt = s_q.cnt + 8'h01;
                if (s_q.cnt == fmw_pkg::HALF_CELL_CYCLES - 8'h01) begin
                    s_d.cnt = fmw_pkg::HALF_CELL_RST;
                    if (bitValid && !link.emergency) begin
                        s_d.dataBit = bitData;
                        s_d.rdy = 1'b1;
                        s_d.pulse = 1'b1;
                        s_d.st = fmw_pkg::HST_CLOCK;
                    end else begin
                        s_d.gateN = 1'b1;
                        s_d.st = fmw_pkg::HST_IDLE;
                    end
                end
            end
            default: begin
                s_d.st = fmw_pkg::HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q       <= '0;
            s_q.st    <= fmw_pkg::HST_IDLE;
            s_q.gateN <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.platterChoiceLine = s_q.head[1];
    assign link.surfaceChoiceLine = s_q.head[0];
    assign link.writeGateN        = s_q.gateN;
    assign link.writePulseLine    = s_q.pulse;
    assign bitReady               = s_q.rdy;
    assign busy                   = ~s_q.gateN;
endmodule : fmw_host_end
`default_nettype wire

// >>> verification/fmw_chk.sv
// Assertions on the link between host end and drive end.
`timescale 1ns/1ps
`default_nettype none
module fmw_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       platterChoiceLine,
    input wire logic       surfaceChoiceLine,
    input wire logic [3:0] headSelectOneHot,
    input wire logic       writeGateN,
    input wire logic       writePulseLine,
    input wire logic       emergency
);
    logic [2:0] phase_q;
    always_ff @(posedge clk) phase_q <= writeGateN ? 3'h0 : phase_q + 3'h1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_one_head: assert property ($onehot0(headSelectOneHot))
        else $error("more than one head selected");
    a_head_decode: assert property (!writeGateN |->
        headSelectOneHot == 4'h1 << {platterChoiceLine, surfaceChoiceLine})
        else $error("head decode wrong");
    a_cell_clock: assert property (!writeGateN && phase_q == 3'h0 |-> writePulseLine)
        else $error("cell without clock pulse");
    a_cell_quiet: assert property (!writeGateN && phase_q != 3'h0 && phase_q != 3'h4
        |-> !writePulseLine)
        else $error("pulse outside clock or data slot");
    a_pulse_gated: assert property (writePulseLine |-> !writeGateN)
        else $error("pulse without write gate");
    a_pulse_short: assert property (writePulseLine |=> !writePulseLine)
        else $error("pulse longer than one cycle");
    a_reset_idle: assert property (disable iff (1'b0) !nrst |=>
        writeGateN && !emergency && !writePulseLine)
        else $error("link not idle in reset");
    a_select_hold: assert property (!writeGateN && $past(!writeGateN)
        |-> $stable({platterChoiceLine, surfaceChoiceLine}))
        else $error("head select moved during write");
    cover property (!writeGateN && phase_q == 3'h4 && writePulseLine);
    cover property (emergency);
    cover property ($rose(writeGateN));
endmodule : fmw_chk
`default_nettype wire

// >>> verification/test_fm_write_channel_control.sv
// Self-checking bench with host end and drive end joined by the link.
`timescale 1ns/1ps
`default_nettype none
module test_fm_write_channel_control;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [1:0] headIndex = 2'h2;
    logic       bitValid = 1'b0;
    logic       bitData = 1'b0;
    logic       powerGood = 1'b1;
    logic       tpi200 = 1'b0;
    logic [8:0] cylinder = 9'h000;
    logic       wSense = 1'b0;
    logic       eSense = 1'b0;
    logic       bitReady, busy, wmN, ecN, tgl, hiCur, monN, coilA, coilB;
    int         fail_count = 0, checks = 0, cycles = 0, pulses = 0, toggles = 0;
    logic [9:0] lv [4] = '{10'h07f, 10'h080, 10'h2ff, 10'h300};
    fmw_link_if link ();
    fmw_host_end i_fmw_host_end (.clk(clk), .nrst(nrst), .link(link),
        .headIndex(headIndex), .driveReady(1'b1), .bitValid(bitValid),
        .bitData(bitData), .bitReady(bitReady), .busy(busy));
    fmw_drive_end i_fmw_drive_end (.clk(clk), .nrst(nrst), .link(link),
        .unitReady(1'b1), .onLegalTrack(1'b1), .writeProtect(1'b0),
        .powerGoodClear(powerGood), .tpi200(tpi200), .cylinder(cylinder),
        .writeCurrentSensed(wSense), .eraseCurrentSensed(eSense),
        .writeModeEnableN(wmN), .eraseCurrentEnableN(ecN), .writeTogglePulse(tgl),
        .highCurrentLevel(hiCur), .currentMonitorN(monN), .coilHalfA(coilA),
        .coilHalfB(coilB));
    fmw_chk u_chk (.clk(clk), .nrst(nrst), .platterChoiceLine(link.platterChoiceLine),
        .surfaceChoiceLine(link.surfaceChoiceLine),
        .headSelectOneHot(link.headSelectOneHot), .writeGateN(link.writeGateN),
        .writePulseLine(link.writePulseLine), .emergency(link.emergency));
    always #12.5 clk = ~clk;
    task automatic conclude();
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Sends n bits back to back, lowest first, holding the request until taken.
    task automatic stream(input logic [7:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            bitValid = 1'b1;
            bitData = bits[i];
            do @(negedge clk); while (bitReady !== 1'b1);
            if (i > 0) check({wmN, ecN, coilA ^ coilB}, 3'h1);
        end
        bitValid = 1'b0;
    endtask : stream
    always @(posedge clk) begin
        pulses += (link.writePulseLine === 1'b1);
        toggles += (tgl === 1'b1);
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check({wmN, ecN, link.emergency}, 3'h6);
        $display("Test reset done");
        stream(8'h0d, 5);
        repeat (12) @(negedge clk);
        check(pulses, 16'h8);
        check(toggles, 16'h8);
        check({wmN, ecN, busy}, 3'h6);
        $display("Test stream done");
        for (int i = 0; i < 4; i++) begin
            {tpi200, cylinder} = lv[i];
            repeat (3) @(negedge clk);
            check(hiCur, (i % 2) == 0);
        end
        $display("Test current level done");
        powerGood = 1'b0;
        stream(8'h01, 1);
        repeat (2) @(negedge clk);
        check({ecN, coilA, coilB}, 3'h4);
        repeat (12) @(negedge clk);
        powerGood = 1'b1;
        $display("Test power fail done");
        for (int j = 0; j < 2; j++) begin
            {wSense, eSense} = (j == 0) ? 2'h2 : 2'h1;
            repeat (3) @(negedge clk);
            check({monN, link.emergency}, 2'h1);
            {wSense, eSense} = 2'h0;
            nrst = 1'b0;
            repeat (2) @(negedge clk);
            nrst = 1'b1;
            @(negedge clk);
        end
        $display("Test emergency done");
        conclude();
    end
endmodule : test_fm_write_channel_control
`default_nettype wire
